// ==== rtl/tpm_pkg.sv ====
// constants and types shared by the terminal panel mode control
package tpm_pkg;
    // break spacing interval limits, milliseconds
    localparam int BREAK_MIN_MS   = 380;
    localparam int BREAK_MAX_MS   = 750;
    // target break length chosen between the limits
    localparam int BREAK_MS       = 500;
    localparam int CLK_HZ         = 40000000;
    // cycles of break, fits comfortably inside both limits
    localparam int BREAK_CYCLES   = BREAK_MS * (CLK_HZ / 1000);
    // button debounce settle time in microseconds
    localparam int DEBOUNCE_US    = 5000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1000000);
    // received and punched control character codes
    localparam logic [7:0] CHR_ACK = 8'h06;
    localparam logic [7:0] CHR_NAK = 8'h15;
    localparam logic [7:0] CHR_DC1 = 8'h11;
    localparam logic [7:0] CHR_DC3 = 8'h13;
    localparam logic [7:0] CHR_BS  = 8'h08;
    localparam logic [7:0] CHR_CR  = 8'h0D;
    // default line length and column counter width
    localparam int LINE_LEN_DEF   = 72;
    localparam int COL_W          = 8;
    // pushbutton indices
    localparam int BTN_OFFLINE    = 0;
    localparam int BTN_BREAK      = 1;
    localparam int BTN_READY      = 2;
    localparam int BTN_IDENT      = 3;
    localparam int BTN_FAULT      = 4;
    localparam int BTN_RDR_AUTO   = 5;
    localparam int BTN_KBD_OFF    = 6;
    localparam int BTN_PTR_OFF    = 7;
    localparam int BTN_RDR_OFF    = 8;
    localparam int BTN_PUN_OFF    = 9;
    localparam int BTN_PUN_EN     = 10;
    localparam int NUM_BTN        = 11;
    typedef enum logic {TPM_BRK_IDLE, TPM_BRK_SPACE} tpm_brk_state_t;
endpackage : tpm_pkg

// ==== rtl/tpm_debounce.sv ====
// synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ps
module tpm_debounce #(
    parameter int SETTLE = tpm_pkg::DEBOUNCE_CYCLES // stable cycles needed
) (
    input  wire logic clk,     // system clock
    input  wire logic rst_n,   // synchronous reset, active low
    input  wire logic btn_raw, // raw pushbutton, high while pressed
    output logic      level,   // debounced level
    output logic      press    // one-cycle pulse on press edge
);
    localparam int CW = $clog2(SETTLE + 1);
    initial begin
        if (SETTLE < 1) $error("settle count must be positive");
    end
    logic          meta_q;
    logic          sync_q;
    logic          level_q;
    logic [CW-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////
    // two-flop synchroniser, first stage read only by second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= btn_raw;
            sync_q <= meta_q;
        end
    end

    // level accepted only after it stays put for the settle time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
        end else if (sync_q == level_q) begin
            cnt_q <= '0;
        end else if (cnt_q == CW'(SETTLE - 1)) begin
            cnt_q   <= '0;
            level_q <= sync_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign level = level_q;
    assign press = (sync_q != level_q) && sync_q && (cnt_q == CW'(SETTLE - 1));
endmodule : tpm_debounce

// ==== rtl/tpm_break_timer.sv ====
// timed spacing interval generator for the line break
`timescale 1ns/1ps
module tpm_break_timer #(
    parameter int CYCLES = tpm_pkg::BREAK_CYCLES // length of spacing
) (
    input  wire logic clk,    // system clock
    input  wire logic rst_n,  // synchronous reset, active low
    input  wire logic start,  // pulse starts an interval
    output logic      active  // high while line is held spacing
);
    localparam int CW = $clog2(CYCLES + 1);
    initial begin
        if (CYCLES < 2) $error("break length too short");
    end
    tpm_pkg::tpm_brk_state_t state_q;
    logic [CW-1:0]           cnt_q;

    ////////////////////////////////////////////////////////////////
    // presses during a running break are ignored, not stretched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= tpm_pkg::TPM_BRK_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                tpm_pkg::TPM_BRK_IDLE: begin
                    if (start) begin
                        state_q <= tpm_pkg::TPM_BRK_SPACE;
                        cnt_q   <= CW'(CYCLES - 1);
                    end
                end
                tpm_pkg::TPM_BRK_SPACE: begin
                    if (cnt_q == '0) begin
                        state_q <= tpm_pkg::TPM_BRK_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: state_q <= tpm_pkg::TPM_BRK_IDLE;
            endcase
        end
    end

    assign active = (state_q == tpm_pkg::TPM_BRK_SPACE);
endmodule : tpm_break_timer

// ==== rtl/tpm_panel.sv ====
// control panel mode, lamp and flow logic of a printing terminal
// Summary of operation
// - offline button toggles whole terminal local
// - offline press during call forces disconnect
// - paper feed runs while button held, local
// - carriage home button returns carriage locally
// - break holds line spacing 380 to 750 ms
// - ready lamp lit by button or ACK
// - ready lamp off on NAK, break, call end
// - identify starts answer-back only when on-line
// - fault lamp on low paper, optional parity
// - fault button clears parity fault only
// - printer limit lamp at column, off newline
// - reader auto toggles; DC1 starts, DC3 stops
// - keyboard offline lights lamp, motor, local
// - printer offline toggles lamp, motor, local
// - reader offline toggles lamp, motor, local
// - punch offline toggles lamp and local mode
// - tape counter lights keyboard line lamp
// - counter down on backspace, zero on return
// - NAK inhibits keyboard and reader, ACK enables
`timescale 1ns/1ps
module tpm_panel #(
    parameter int COL_W    = tpm_pkg::COL_W,           // column counter width
    parameter int SETTLE   = tpm_pkg::DEBOUNCE_CYCLES, // debounce cycles
    parameter int BRK_CYC  = tpm_pkg::BREAK_CYCLES     // break length cycles
) (
    input  wire logic             clk,                  // system clock 40 MHz
    input  wire logic             rst_n,                // synchronous reset
    input  wire logic             offline_button,       // whole terminal local toggle
    input  wire logic             paper_feed_button,    // paper feed, held
    input  wire logic             carriage_home_button, // local carriage return
    input  wire logic             break_button,         // send line break
    input  wire logic             send_ready_button,    // mark ready to send
    input  wire logic             identify_button,      // start answer-back
    input  wire logic             fault_button,         // clear parity fault
    input  wire logic             reader_auto_button,   // auto reader control toggle
    input  wire logic             keyboard_offline_button, // keyboard local
    input  wire logic             printer_offline_button,  // printer local toggle
    input  wire logic             reader_offline_button,   // reader local toggle
    input  wire logic             punch_offline_button,    // punch local toggle
    input  wire logic             punch_enable_button,     // punch selector toggle
    input  wire logic             call_active,          // data call in progress
    input  wire logic             rx_valid,             // received character strobe
    input  wire logic [7:0]       rx_char,              // received character
    input  wire logic             rx_parity_err,        // with rx_valid, bad parity
    input  wire logic             rx_break,             // break seen on the line
    input  wire logic             low_paper,            // paper supply low
    input  wire logic             parity_alarm_en,      // option: parity lights fault
    input  wire logic             print_adv,            // print position advanced
    input  wire logic             print_newline,        // new printed line started
    input  wire logic [COL_W-1:0] print_line_limit,     // printer line length
    input  wire logic             punch_char,           // char punched from keyboard
    input  wire logic [7:0]       punch_code,           // code of punched char
    input  wire logic [COL_W-1:0] tape_line_limit,      // chars per tape line
    output logic                  offline_lamp,         // terminal local lamp
    output logic                  terminal_local,       // terminal in local mode
    output logic                  force_disconnect,     // pulse drops the call
    output logic                  paper_feed,           // feed paper motion
    output logic                  carriage_home,        // pulse returns carriage
    output logic                  tx_spacing,           // hold transmit line spacing
    output logic                  send_ready_lamp,      // ready to send lamp
    output logic                  answerback_start,     // pulse starts answer-back
    output logic                  fault_lamp,           // fault lamp
    output logic                  printer_line_limit_lamp, // printer end of line
    output logic                  reader_auto_lamp,     // auto reader lamp
    output logic                  reader_run,           // reader advance enable
    output logic                  keyboard_offline_lamp,// keyboard local lamp
    output logic                  keyboard_local,       // keyboard local mode
    output logic                  printer_offline_lamp, // printer local lamp
    output logic                  printer_local,        // printer local mode
    output logic                  printer_motor,        // printer motor on
    output logic                  reader_offline_lamp,  // reader local lamp
    output logic                  reader_local,         // reader local mode
    output logic                  reader_motor,         // reader motor on
    output logic                  punch_offline_lamp,   // punch local lamp
    output logic                  punch_local,          // punch local mode
    output logic                  punch_enable_lamp,    // punch enable lamp
    output logic                  punch_blind,          // punch selector blinded
    output logic                  tx_inhibit,           // keyboard/reader tx blinded
    output logic                  tape_line_count_lamp  // keyboard end of line
);
    initial begin
        if (COL_W < 2) $error("column width too small");
    end

    ////////////////////////////////////////////////////////////////
    // button conditioning, one debouncer per button
    logic [tpm_pkg::NUM_BTN-1:0] raw;
    logic [tpm_pkg::NUM_BTN-1:0] prs;
    logic                        feed_lvl;
    assign raw[tpm_pkg::BTN_OFFLINE]  = offline_button;
    assign raw[tpm_pkg::BTN_BREAK]    = break_button;
    assign raw[tpm_pkg::BTN_READY]    = send_ready_button;
    assign raw[tpm_pkg::BTN_IDENT]    = identify_button;
    assign raw[tpm_pkg::BTN_FAULT]    = fault_button;
    assign raw[tpm_pkg::BTN_RDR_AUTO] = reader_auto_button;
    assign raw[tpm_pkg::BTN_KBD_OFF]  = keyboard_offline_button;
    assign raw[tpm_pkg::BTN_PTR_OFF]  = printer_offline_button;
    assign raw[tpm_pkg::BTN_RDR_OFF]  = reader_offline_button;
    assign raw[tpm_pkg::BTN_PUN_OFF]  = punch_offline_button;
    assign raw[tpm_pkg::BTN_PUN_EN]   = punch_enable_button;

    for (genvar i = 0; i < tpm_pkg::NUM_BTN; i++) begin : g_btn
        tpm_debounce #(.SETTLE(SETTLE)) u_db (
            .clk     (clk),
            .rst_n   (rst_n),
            .btn_raw (raw[i]),
            .level   (),
            .press   (prs[i])
        );
    end

    // feed and home buttons also debounced; feed uses the level, home the press pulse
    logic home_prs;
    tpm_debounce #(.SETTLE(SETTLE)) u_db_feed (
        .clk     (clk),
        .rst_n   (rst_n),
        .btn_raw (paper_feed_button),
        .level   (feed_lvl),
        .press   ()
    );
    tpm_debounce #(.SETTLE(SETTLE)) u_db_home (
        .clk     (clk),
        .rst_n   (rst_n),
        .btn_raw (carriage_home_button),
        .level   (),
        .press   (home_prs)
    );

    ////////////////////////////////////////////////////////////////
    // received character decode
    logic rx_ack;
    logic rx_nak;
    logic rx_dc1;
    logic rx_dc3;
    assign rx_ack = rx_valid && (rx_char == tpm_pkg::CHR_ACK);
    assign rx_nak = rx_valid && (rx_char == tpm_pkg::CHR_NAK);
    assign rx_dc1 = rx_valid && (rx_char == tpm_pkg::CHR_DC1);
    assign rx_dc3 = rx_valid && (rx_char == tpm_pkg::CHR_DC3);

    ////////////////////////////////////////////////////////////////
    // terminal offline toggle and forced disconnect
    logic term_local_q;
    logic disc_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            term_local_q <= 1'b0;
            disc_q       <= 1'b0;
        end else begin
            if (prs[tpm_pkg::BTN_OFFLINE]) begin
                term_local_q <= !term_local_q;
            end
            disc_q <= prs[tpm_pkg::BTN_OFFLINE] && call_active;
        end
    end

    // purely local mechanism actions, nothing goes to the line
    logic feed_q;
    logic home_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            feed_q <= 1'b0;
            home_q <= 1'b0;
        end else begin
            feed_q <= feed_lvl;
            home_q <= home_prs;
        end
    end

    ////////////////////////////////////////////////////////////////
    // timed break on the transmit line
    tpm_break_timer #(.CYCLES(BRK_CYC)) u_brk (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (prs[tpm_pkg::BTN_BREAK]),
        .active (tx_spacing)
    );

    ////////////////////////////////////////////////////////////////
    // send-ready lamp and transmit blinding; turn-off events win
    logic ready_q;
    logic inhibit_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_q   <= 1'b0;
            inhibit_q <= 1'b0;
        end else begin
            if (rx_nak || rx_break || !call_active) begin
                ready_q <= 1'b0;
            end else if ((prs[tpm_pkg::BTN_READY] && !ready_q) || rx_ack) begin
                ready_q <= 1'b1;
            end
            if (rx_nak) begin
                inhibit_q <= 1'b1;
            end else if (rx_ack) begin
                inhibit_q <= 1'b0;
            end
        end
    end

    // answer-back start, refused while the terminal is local
    logic ab_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ab_q <= 1'b0;
        end else begin
            ab_q <= prs[tpm_pkg::BTN_IDENT] && !term_local_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // fault lamp: paper part follows level, parity part is sticky
    logic par_fault_q;
    logic fault_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            par_fault_q <= 1'b0;
            fault_q     <= 1'b0;
        end else begin
            // a new parity error in the clear cycle still sets
            if (rx_valid && rx_parity_err && parity_alarm_en) begin
                par_fault_q <= 1'b1;
            end else if (prs[tpm_pkg::BTN_FAULT]) begin
                par_fault_q <= 1'b0;
            end
            fault_q <= low_paper || par_fault_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // printer column counter and limit lamp
    logic [COL_W-1:0] pcol_q;
    logic             plim_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcol_q <= '0;
            plim_q <= 1'b0;
        end else if (print_newline) begin
            pcol_q <= '0;
            plim_q <= 1'b0;
        end else begin
            if (print_adv && pcol_q != '1) begin
                pcol_q <= pcol_q + 1'b1;
            end
            plim_q <= (pcol_q >= print_line_limit);
        end
    end

    ////////////////////////////////////////////////////////////////
    // reader auto control by received DC1 and DC3
    logic rauto_q;
    logic rrun_q;
    logic ptr_local_q;
    logic rdr_local_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rauto_q <= 1'b0;
            rrun_q  <= 1'b0;
        end else begin
            if (prs[tpm_pkg::BTN_RDR_AUTO]) begin
                rauto_q <= !rauto_q;
            end
            if (rauto_q && !rdr_local_q && !ptr_local_q) begin
                if (rx_dc3) begin
                    rrun_q <= 1'b0;
                end else if (rx_dc1) begin
                    rrun_q <= 1'b1;
                end
            end else begin
                rrun_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // unit local modes; keyboard local only sets, per its button
    logic keyboard_offline_button_q;
    logic pun_local_q;
    logic pun_en_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            keyboard_offline_button_q <= 1'b0;
            ptr_local_q <= 1'b0;
            rdr_local_q <= 1'b0;
            pun_local_q <= 1'b0;
            pun_en_q    <= 1'b0;
        end else begin
            if (prs[tpm_pkg::BTN_KBD_OFF]) begin
                keyboard_offline_button_q <= 1'b1;
            end
            if (prs[tpm_pkg::BTN_PTR_OFF]) begin
                ptr_local_q <= !ptr_local_q;
            end
            if (prs[tpm_pkg::BTN_RDR_OFF]) begin
                rdr_local_q <= !rdr_local_q;
            end
            if (prs[tpm_pkg::BTN_PUN_OFF]) begin
                pun_local_q <= !pun_local_q;
            end
            if (prs[tpm_pkg::BTN_PUN_EN]) begin
                pun_en_q <= !pun_en_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // tape line character counter
    logic [COL_W-1:0] tcnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tcnt_q <= '0;
        end else if (punch_char) begin
            if (punch_code == tpm_pkg::CHR_CR) begin
                tcnt_q <= '0;
            end else if (punch_code == tpm_pkg::CHR_BS) begin
                if (tcnt_q != '0) begin
                    tcnt_q <= tcnt_q - 1'b1;
                end
            end else if (tcnt_q != '1) begin
                tcnt_q <= tcnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign offline_lamp            = term_local_q;
    assign terminal_local          = term_local_q;
    assign force_disconnect        = disc_q;
    assign paper_feed              = feed_q;
    assign carriage_home           = home_q;
    assign send_ready_lamp         = ready_q;
    assign answerback_start        = ab_q;
    assign fault_lamp              = fault_q;
    assign printer_line_limit_lamp = plim_q;
    assign reader_auto_lamp        = rauto_q;
    assign reader_run              = rrun_q;
    assign keyboard_offline_lamp   = keyboard_offline_button_q;
    assign keyboard_local          = keyboard_offline_button_q;
    assign printer_offline_lamp    = ptr_local_q;
    assign printer_local           = ptr_local_q;
    assign printer_motor           = ptr_local_q || keyboard_offline_button_q;
    assign reader_offline_lamp     = rdr_local_q;
    assign reader_local            = rdr_local_q;
    assign reader_motor            = rdr_local_q;
    assign punch_offline_lamp      = pun_local_q;
    assign punch_local             = pun_local_q;
    assign punch_enable_lamp       = pun_en_q;
    assign punch_blind             = !pun_en_q;
    assign tx_inhibit              = inhibit_q;
    assign tape_line_count_lamp    = (tcnt_q >= tape_line_limit);
endmodule : tpm_panel

// ==== testbench/tpm_operator.sv ====
// operator model pressing one panel button at a time
`timescale 1ns/1ps
module tpm_operator #(
    parameter int SETTLE = 4 // debounce span of the panel
) (
    input wire logic    clk, // system clock
    output logic [12:0] btn  // buttons, high while held
);
    initial btn = '0;
    // contact bounce shorter than the settle span, then a firm hold and a stable release
    task automatic press(input int i);
        btn[i] = 1'b1;
        @(negedge clk) btn[i] = 1'b0;
        @(negedge clk) btn[i] = 1'b1;
        repeat (SETTLE + 8) @(negedge clk);
        btn[i] = 1'b0;
        repeat (SETTLE + 8) @(negedge clk);
    endtask : press
endmodule : tpm_operator

// ==== testbench/tpm_panel_monitor.sv ====
// checker of port relations of the panel
`timescale 1ns/1ps
module tpm_panel_monitor #(
    parameter int BRK_CYC = tpm_pkg::BREAK_CYCLES // break length in cycles
) (
    input wire logic       clk, rst_n, call_active, rx_valid, rx_break, low_paper, tx_spacing, send_ready_lamp,
    input wire logic       tx_inhibit, fault_lamp, punch_blind, punch_enable_lamp, answerback_start, terminal_local,
    input wire logic [7:0] rx_char
);
    logic [31:0] spc_q; // cycles spent spacing
    // a counter keeps the long break count out of a repetition
    always_ff @(posedge clk) spc_q <= (!rst_n || !tx_spacing) ? '0 : spc_q + 32'h1;
    ////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_ready: assert property (
        rx_valid && rx_char == tpm_pkg::CHR_ACK && call_active && !rx_break |=> send_ready_lamp && !tx_inhibit)
        else $error("ack missed");
    a_nak_inhibit: assert property (
        rx_valid && rx_char == tpm_pkg::CHR_NAK |=> !send_ready_lamp && tx_inhibit) else $error("nak missed");
    a_break_dark: assert property (rx_break |=> !send_ready_lamp) else $error("break missed");
    a_call_end: assert property (!call_active |=> !send_ready_lamp) else $error("call end missed");
    a_break_len: assert property ($fell(tx_spacing) |-> spc_q == BRK_CYC) else $error("break length");
    a_paper_fault: assert property (low_paper |=> fault_lamp) else $error("low paper missed");
    a_blind_state: assert property (punch_blind != punch_enable_lamp) else $error("blind state");
    a_ident_online: assert property (answerback_start |-> !$past(terminal_local)) else $error("local id");
endmodule : tpm_panel_monitor
bind tpm_panel tpm_panel_monitor #(.BRK_CYC(BRK_CYC)) mon_u (.clk, .rst_n, .call_active, .rx_valid, .rx_break,
    .low_paper, .tx_spacing, .send_ready_lamp, .tx_inhibit, .fault_lamp, .punch_blind, .punch_enable_lamp,
    .answerback_start, .terminal_local, .rx_char);

// ==== testbench/test_tpm_panel.sv ====
// self-checking bench of the panel mode control
`timescale 1ns/1ps
module test_tpm_panel;
    localparam int BRK = 50; // short break keeps the run brief
    logic clk = '0, rst_n = '0, call_active = '1, rx_parity_err = '0, low_paper = '0;
    logic parity_alarm_en = '0;
    logic [4:0] st = '0; // strobes pulsed by index
    wire logic rx_valid = st[0], rx_break = st[1], print_adv = st[2], print_newline = st[3], punch_char = st[4];
    logic [7:0] rx_char = '0, punch_code = 8'h41, print_line_limit = 8'h02, tape_line_limit = 8'h03, sc = '0;
    logic [12:0] btn;
    logic [3:0] seen = '0; // feed, home, answer-back and disconnect seen
    int fail_count = 0, cmp_count = 0;
    wire logic offline_lamp, terminal_local, force_disconnect, paper_feed, carriage_home, tx_spacing, send_ready_lamp,
        answerback_start, fault_lamp, printer_line_limit_lamp, reader_auto_lamp, reader_run, keyboard_offline_lamp,
        keyboard_local, printer_offline_lamp, printer_local, printer_motor, reader_offline_lamp, reader_local,
        reader_motor, punch_offline_lamp, punch_local, punch_enable_lamp, punch_blind, tx_inhibit, tape_line_count_lamp;
    wire logic [9:0] modes = {reader_motor, reader_local, printer_motor, printer_local, punch_local,
        punch_enable_lamp, punch_offline_lamp, reader_offline_lamp, printer_offline_lamp, reader_auto_lamp};
    tpm_operator #(.SETTLE(4)) op_u (.clk, .btn);
    tpm_panel #(.SETTLE(4), .BRK_CYC(BRK)) dut_u (.offline_button(btn[0]), .break_button(btn[1]),
        .send_ready_button(btn[2]), .identify_button(btn[3]), .fault_button(btn[4]), .reader_auto_button(btn[5]),
        .keyboard_offline_button(btn[6]), .printer_offline_button(btn[7]), .reader_offline_button(btn[8]),
        .punch_offline_button(btn[9]), .punch_enable_button(btn[10]), .paper_feed_button(btn[11]),
        .carriage_home_button(btn[12]), .*);
    // one-cycle pulses would slip between checks, so they are held
    always @(posedge clk) begin
        seen <= seen | {paper_feed, carriage_home, answerback_start, force_disconnect};
        sc <= sc + 8'(tx_spacing);
    end
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input int i);
        st[i] = '1;
        @(negedge clk) st[i] = '0;
        repeat (2) @(negedge clk);
    endtask : pulse
    task automatic rx(input logic [7:0] c);
        rx_char = c;
        pulse(0);
    endtask : rx
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    ////////////////////////////////
    task automatic t_offline;
        op_u.press(0);
        chk({offline_lamp, terminal_local, seen[1:0]}, 4'hD);
        op_u.press(3);
        op_u.press(0);
        chk({offline_lamp, seen[1:0]}, 3'h1);
        op_u.press(3);
        chk(seen[1], 1'b1);
    endtask : t_offline
    task automatic t_ready;
        rx(tpm_pkg::CHR_NAK);
        chk({send_ready_lamp, tx_inhibit}, 2'h1);
        rx(tpm_pkg::CHR_ACK);
        chk({send_ready_lamp, tx_inhibit}, 2'h2);
        pulse(1);
        chk(send_ready_lamp, 1'b0);
        op_u.press(2);
        chk(send_ready_lamp, 1'b1);
        call_active = '0;
        repeat (2) @(negedge clk);
        chk(send_ready_lamp, 1'b0);
        op_u.press(1);
        repeat (BRK) @(negedge clk);
        chk(sc, 16'(BRK));
    endtask : t_ready
    task automatic t_fault;
        rx_parity_err = '1;
        rx(8'h41);
        chk(fault_lamp, 1'b0);
        parity_alarm_en = '1;
        rx(8'h41);
        rx_parity_err = '0;
        chk(fault_lamp, 1'b1);
        op_u.press(4);
        chk(fault_lamp, 1'b0);
        low_paper = '1;
        op_u.press(4);
        chk(fault_lamp, 1'b1);
    endtask : t_fault
    task automatic t_modes;
        int b[5] = '{5, 7, 8, 9, 10};
        logic [15:0] e[5] = '{16'h001, 16'h0C2, 16'h304, 16'h028, 16'h010};
        foreach (b[k]) begin
            op_u.press(b[k]);
            chk(modes, e[k]);
            op_u.press(b[k]);
            chk(modes, 16'h000);
        end
        op_u.press(5);
        rx(tpm_pkg::CHR_DC1);
        chk(reader_run, 1'b1);
        rx(tpm_pkg::CHR_DC3);
        chk(reader_run, 1'b0);
        op_u.press(6);
        chk({keyboard_offline_lamp, keyboard_local, printer_motor}, 3'h7);
    endtask : t_modes
    task automatic t_count;
        repeat (3) pulse(4);
        chk(tape_line_count_lamp, 1'b1);
        punch_code = tpm_pkg::CHR_BS;
        pulse(4);
        chk(tape_line_count_lamp, 1'b0);
        tape_line_limit = 8'h02;
        punch_code = tpm_pkg::CHR_CR;
        pulse(4);
        punch_code = 8'h41;
        pulse(4);
        chk(tape_line_count_lamp, 1'b0);
        pulse(4);
        chk(tape_line_count_lamp, 1'b1);
        repeat (2) pulse(2);
        chk(printer_line_limit_lamp, 1'b1);
        pulse(3);
        chk(printer_line_limit_lamp, 1'b0);
    endtask : t_count
    task automatic t_local;
        op_u.press(11);
        chk({paper_feed, seen[3:2]}, 3'h2);
        op_u.press(12);
        chk(seen[3:2], 2'h3);
    endtask : t_local
    initial begin
        repeat (8) @(negedge clk);
        rst_n = '1;
        chk({offline_lamp, send_ready_lamp, fault_lamp, tx_spacing, punch_blind, tx_inhibit, modes}, 16'h0800);
        t_offline();
        t_ready();
        t_fault();
        t_modes();
        t_count();
        t_local();
        finish_test();
    end
    // watchdog, several times the expected run
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule : test_tpm_panel
